// file: ldst_unit.sv
// Single-register load/store execution unit with Wishbone registers.
// Assumes the core supplies register values (r15 already as PC+8),
// an evaluated condition flag and the shifter carry, all on CLOCK.
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module ldst_unit
    import ldst_pkg::*;
(
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    // Instruction issue from the decoder
    input  wire logic        INSTR_VALID,
    output logic             INSTR_READY,
    input  wire logic [31:0] INSTR,
    input  wire logic        COND_PASS,
    input  wire logic        CARRY_IN,
    input  wire logic [31:0] RN_VALUE,
    input  wire logic [31:0] RM_VALUE,
    input  wire logic [31:0] RD_VALUE,
    // Register file writeback
    output logic             RD_WE,
    output logic [3:0]       RD_IDX,
    output logic [31:0]      RD_DATA,
    output logic             RN_WE,
    output logic [3:0]       RN_IDX,
    output logic [31:0]      RN_DATA,
    output logic             DONE,
    output logic             BAD_INSTR,
    // Memory data port
    output logic             MEM_REQ,
    output logic             MEM_WE,
    output logic [1:0]       MEM_SIZE,
    output logic             MEM_USER,
    output logic [31:0]      MEM_ADDR,
    output logic [31:0]      MEM_WDATA,
    input  wire logic [31:0] MEM_RDATA,
    input  wire logic        MEM_ACK,
    // Wishbone classic slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic [31:0]      WB_DAT_O,
    output logic             WB_ACK_O
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MEM  = 2'b01
    } state_t;

    typedef struct packed {
        state_t      st;
        logic [31:0] addr;
        logic [31:0] base_new;
        logic [31:0] wdata;
        size_t       size;
        logic        load;
        logic        sign;
        logic        wback;
        logic        user;
        logic [3:0]  rd_idx;
        logic [3:0]  rn_idx;
        logic [31:0] rd_data;
        logic        rd_we;
        logic        rn_we;
        logic        done;
        logic        bad;
        logic        enable;
        logic [31:0] last_addr;
        logic [31:0] xfers;
        logic [15:0] errs;
        logic        ack;
        logic [31:0] dat;
    } regs_t;

    regs_t r_reg;
    regs_t r_next;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic        word_cls;
    logic        half_cls;
    logic        reg_form;
    logic        bad_form;
    logic [31:0] shifted;
    logic [31:0] offset;
    logic [31:0] sum;
    logic [31:0] ea;
    logic [4:0]  amt;
    logic        accept;
    logic        go;
    size_t       sz;

    // Class detection; other opcodes here are not this unit's work
    assign word_cls = INSTR[27:26] == 2'b01;
    assign half_cls = INSTR[27:25] == 3'b000 && INSTR[7] && INSTR[4]
                      && INSTR[6:5] != 2'b00;
    assign reg_form = word_cls ? INSTR[BIT_I] : !INSTR[BIT_B];
    assign amt      = INSTR[11:7];

    // Offset shifter; a zero amount on a right shift or rotate encodes 32 or extend-by-carry
    always_comb begin
        case (shift_t'(INSTR[6:5]))
            SHIFT_LEFT_LOGICAL:  shifted = RM_VALUE << amt;
            SHIFT_RIGHT_LOGICAL: shifted = (amt == 5'h0) ? 32'h0
                                           : RM_VALUE >> amt;
            SHIFT_RIGHT_ARITH:   shifted = (amt == 5'h0)
                                           ? {32{RM_VALUE[31]}}
                                           : 32'($signed(RM_VALUE) >>> amt);
            ROTATE_RIGHT:        shifted = (amt == 5'h0)
                                           ? {CARRY_IN, RM_VALUE[31:1]}
                                           : (RM_VALUE >> amt)
                                             | (RM_VALUE << (6'd32 - amt));
            default:             shifted = RM_VALUE;
        endcase
    end

    // Offset form selection
    always_comb begin
        if (word_cls && !reg_form)
            offset = {20'h0, INSTR[IMM12_W-1:0]};
        else if (word_cls)
            offset = shifted;
        else if (!reg_form)
            offset = {24'h0, INSTR[11:8], INSTR[3:0]};
        else
            offset = RM_VALUE;
    end

    // Base may be r15, already presented as PC+8 by the core
    assign sum = INSTR[BIT_U] ? RN_VALUE + offset
                              : RN_VALUE - offset;
    assign ea  = INSTR[BIT_P] ? sum : RN_VALUE;

    // PC as offset register, word-class bit 4 in register form and a
    // signed store are all refused rather than guessed at
    assign bad_form = !(word_cls || half_cls)
                      || (reg_form && INSTR[3:0] == PC_IDX)
                      || (word_cls && reg_form && INSTR[4])
                      || (half_cls && !INSTR[BIT_L] && INSTR[BIT_S])
                      || (half_cls && !INSTR[BIT_P] && INSTR[BIT_W]);

    // Access size
    always_comb begin
        if (word_cls)
            sz = INSTR[BIT_B] ? SZ_BYTE : SZ_WORD;
        else
            sz = INSTR[BIT_H] ? SZ_HALF : SZ_BYTE;
    end

    assign INSTR_READY = r_reg.st == ST_IDLE && r_reg.enable;
    assign accept      = INSTR_VALID && INSTR_READY;
    assign go          = accept && COND_PASS && !bad_form;

    // ------------------------------------------------------------
    // Load data alignment and extension
    // ------------------------------------------------------------
    logic [4:0]  lane;
    logic [31:0] rot;
    logic [15:0] half_d;
    logic [31:0] load_val;

    // Unaligned word loads rotate the addressed byte to the bottom
    assign lane   = {r_reg.addr[1:0], 3'b000};
    assign rot    = (MEM_RDATA >> lane) | (MEM_RDATA << (6'd32 - lane));
    assign half_d = r_reg.addr[1] ? MEM_RDATA[31:16] : MEM_RDATA[15:0];

    always_comb begin
        case (r_reg.size)
            SZ_BYTE: load_val = r_reg.sign
                                ? {{24{rot[7]}}, rot[7:0]}
                                : {24'h0, rot[7:0]};
            SZ_HALF: load_val = r_reg.sign
                                ? {{16{half_d[15]}}, half_d}
                                : {16'h0, half_d};
            default: load_val = rot;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        r_next       = r_reg;
        r_next.rd_we = 1'b0;
        r_next.rn_we = 1'b0;
        r_next.done  = 1'b0;
        r_next.bad   = 1'b0;
        // Ack drops the cycle after it was given
        r_next.ack   = WB_CYC_I && WB_STB_I && !r_reg.ack;
        case (r_reg.st)
            ST_IDLE: begin
                if (accept && !COND_PASS) begin
                    r_next.done = 1'b1;
                end else if (accept && bad_form) begin
                    r_next.bad  = 1'b1;
                    r_next.errs = r_reg.errs + 16'h1;
                end else if (go) begin
                    r_next.st       = ST_MEM;
                    r_next.addr     = ea;
                    r_next.base_new = sum;
                    r_next.size     = sz;
                    r_next.load     = INSTR[BIT_L];
                    r_next.sign     = half_cls && INSTR[BIT_S];
                    r_next.wback    = !INSTR[BIT_P] || INSTR[BIT_W];
                    r_next.user     = word_cls && !INSTR[BIT_P]
                                      && INSTR[BIT_W];
                    r_next.rd_idx   = INSTR[RD_LSB+3:RD_LSB];
                    r_next.rn_idx   = INSTR[RN_LSB+3:RN_LSB];
                    // Narrow stores replicate data across all lanes
                    case (sz)
                        SZ_BYTE: r_next.wdata = {4{RD_VALUE[7:0]}};
                        SZ_HALF: r_next.wdata = {2{RD_VALUE[15:0]}};
                        default: r_next.wdata = RD_VALUE;
                    endcase
                end
            end
            ST_MEM: begin
                if (MEM_ACK) begin
                    r_next.st        = ST_IDLE;
                    r_next.rd_data   = load_val;
                    r_next.rd_we     = r_reg.load;
                    r_next.rn_we     = r_reg.wback;
                    r_next.done      = 1'b1;
                    r_next.last_addr = r_reg.addr;
                    r_next.xfers     = r_reg.xfers + 32'h1;
                end
            end
            default: r_next.st = ST_IDLE;
        endcase
        // Register reads; unmapped offsets read as zero
        case (WB_ADR_I)
            ADR_CTRL:   r_next.dat = {31'h0, r_reg.enable};
            ADR_STATUS: r_next.dat = {30'h0, r_reg.st};
            ADR_LAST:   r_next.dat = r_reg.last_addr;
            ADR_XFERS:  r_next.dat = r_reg.xfers;
            ADR_ERRS:   r_next.dat = {16'h0, r_reg.errs};
            default:    r_next.dat = 32'h0;
        endcase
        // Enable only stalls new issue; a transfer in flight finishes.
        // The write lands on the edge where the master sees ack, so a
        // request dropped before its answer changes nothing.
        if (WB_CYC_I && WB_STB_I && WB_WE_I && r_reg.ack
            && WB_ADR_I == ADR_CTRL && WB_SEL_I[0])
            r_next.enable = WB_DAT_I[0];
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            r_reg        <= '0;
            r_reg.st     <= ST_IDLE;
            r_reg.enable <= CTRL_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs
    assign MEM_REQ   = r_reg.st == ST_MEM;
    assign MEM_WE    = !r_reg.load;
    assign MEM_SIZE  = r_reg.size;
    assign MEM_USER  = r_reg.user;
    assign MEM_ADDR  = r_reg.addr;
    assign MEM_WDATA = r_reg.wdata;
    assign RD_WE     = r_reg.rd_we;
    assign RD_IDX    = r_reg.rd_idx;
    assign RD_DATA   = r_reg.rd_data;
    assign RN_WE     = r_reg.rn_we;
    assign RN_IDX    = r_reg.rn_idx;
    assign RN_DATA   = r_reg.base_new;
    assign DONE      = r_reg.done;
    assign BAD_INSTR = r_reg.bad;
    assign WB_DAT_O  = r_reg.dat;
    assign WB_ACK_O  = r_reg.ack;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    sequence s_go_pre;
        go && INSTR[BIT_P];
    endsequence
    sequence s_go_post;
        go && !INSTR[BIT_P];
    endsequence
    sequence s_acked;
        MEM_REQ && MEM_ACK;
    endsequence

    a_cond_quiet: assert property (accept && !COND_PASS |=>
        !MEM_REQ && !RN_WE && DONE)
        else $error("failed condition caused activity");
    a_pre_addr: assert property (s_go_pre |=>
        MEM_ADDR == RN_DATA && MEM_ADDR == $past(sum))
        else $error("pre-index address wrong");
    a_post_addr: assert property (s_go_post |=>
        MEM_ADDR == $past(RN_VALUE) && RN_DATA == $past(sum))
        else $error("post-index address wrong");
    a_offset_keep: assert property (s_go_pre ##0 !INSTR[BIT_W]
        ##1 s_acked |=> !RN_WE)
        else $error("offset mode wrote base");
    a_post_wback: assert property (s_go_post ##1 s_acked
        |=> RN_WE && DONE)
        else $error("post-index missed writeback");
    a_imm_twelve: assert property (go && word_cls
        && !INSTR[BIT_I] && INSTR[BIT_U] |=>
        RN_DATA == $past(RN_VALUE) + {20'h0, $past(INSTR[11:0])})
        else $error("12-bit offset sum wrong");
    a_direction: assert property (go |=>
        MEM_WE == !$past(INSTR[BIT_L]))
        else $error("direction bit misread");
    a_user_priv: assert property (go && word_cls
        && !INSTR[BIT_P] && INSTR[BIT_W] |=> MEM_USER)
        else $error("user privilege not marked");
    a_ubyte_zero: assert property (RD_WE && r_reg.size == SZ_BYTE
        && !r_reg.sign |-> RD_DATA[31:8] == 24'h0)
        else $error("unsigned byte not zero extended");
    a_uhalf_zero: assert property (RD_WE && r_reg.size == SZ_HALF
        && !r_reg.sign |-> RD_DATA[31:16] == 16'h0)
        else $error("unsigned half not zero extended");
    a_sbyte_sign: assert property (RD_WE && r_reg.size == SZ_BYTE
        && r_reg.sign |-> RD_DATA[31:8] == {24{RD_DATA[7]}})
        else $error("signed byte not sign extended");
    a_req_hold: assert property (MEM_REQ && !MEM_ACK |=>
        MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WDATA))
        else $error("request dropped before ack");
    a_one_xfer: assert property (s_acked |=>
        !MEM_REQ && DONE && RD_WE == !MEM_WE)
        else $error("transfer not closed after ack");
    // Halfword class takes the split 8-bit field, never 12 bits
    a_imm_eight: assert property (go && half_cls
        && !reg_form && INSTR[BIT_U] |=>
        RN_DATA == $past(RN_VALUE)
                   + {24'h0, $past(INSTR[11:8]), $past(INSTR[3:0])})
        else $error("8-bit offset sum wrong");
    a_size_pick: assert property (go && half_cls |=>
        MEM_SIZE == ($past(INSTR[BIT_H]) ? SZ_HALF : SZ_BYTE))
        else $error("halfword size bit misread");
    a_shalf_sign: assert property (RD_WE && r_reg.size == SZ_HALF
        && r_reg.sign |-> RD_DATA[31:16] == {16{RD_DATA[15]}})
        else $error("signed half not sign extended");
endmodule : ldst_unit
`default_nettype wire

// file: ldst_pkg.sv
// Constants for the single-register load/store unit.
// Assumes a 32-bit core with sixteen general registers, r15 the PC.
package ldst_pkg;
    // ------------------------------------------------------------
    // Instruction fields
    // ------------------------------------------------------------
    localparam int BIT_I    = 25;
    localparam int BIT_P    = 24;
    localparam int BIT_U    = 23;
    localparam int BIT_B    = 22;
    localparam int BIT_W    = 21;
    localparam int BIT_L    = 20;
    localparam int BIT_S    = 6;
    localparam int BIT_H    = 5;
    localparam int RN_LSB   = 16;
    localparam int RD_LSB   = 12;
    localparam int IMM12_W  = 12;
    localparam int IMM8_W   = 8;
    localparam logic [3:0] PC_IDX = 4'hf;

    // ------------------------------------------------------------
    // Shift kinds and access sizes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SHIFT_LEFT_LOGICAL  = 2'h0,
        SHIFT_RIGHT_LOGICAL = 2'h1,
        SHIFT_RIGHT_ARITH   = 2'h2,
        ROTATE_RIGHT        = 2'h3
    } shift_t;
    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_HALF = 2'h1,
        SZ_WORD = 2'h2
    } size_t;

    // ------------------------------------------------------------
    // Register map (byte offsets) and reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  ADR_CTRL   = 8'h00;
    localparam logic [7:0]  ADR_STATUS = 8'h04;
    localparam logic [7:0]  ADR_LAST   = 8'h08;
    localparam logic [7:0]  ADR_XFERS  = 8'h0c;
    localparam logic [7:0]  ADR_ERRS   = 8'h10;
    localparam logic        CTRL_RST   = 1'b1;
endpackage : ldst_pkg

// file: ldst_mem_model.sv
// Memory partner model for the load/store unit data port.
// Assumes one access in flight; 64 words indexed by address bits 7:2.
`timescale 1ns/1ps
`default_nettype none
module ldst_mem_model (
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    input  wire logic [3:0]  DELAY,
    input  wire logic        MEM_REQ,
    input  wire logic        MEM_WE,
    input  wire logic [1:0]  MEM_SIZE,
    input  wire logic        MEM_USER,
    input  wire logic [31:0] MEM_ADDR,
    input  wire logic [31:0] MEM_WDATA,
    output logic [31:0]      MEM_RDATA,
    output logic             MEM_ACK
);
    logic [31:0] mem [64];
    logic [3:0]  wait_cnt;
    logic [31:0] churn;
    logic [31:0] last_addr;
    logic [1:0]  last_size;
    logic        last_user;
    int          n_acc;
    logic [5:0]  idx;
    logic [4:0]  lane;
    assign idx  = MEM_ADDR[7:2];
    assign lane = {MEM_ADDR[1:0], 3'h0};
    // Known contents with the sign bit set in the upper three byte lanes
    initial begin
        churn = 32'h5a5a_a5a5;
        for (int k = 0; k < 64; k++) mem[k] = 32'hf1e2_8376 + k;
    end
    // --------------------------------------------------------------
    // Answer in the cycle the wait count reaches DELAY, so a zero
    // delay acks in the first request cycle; idle read lines churn
    // --------------------------------------------------------------
    assign MEM_ACK   = MEM_REQ && wait_cnt == DELAY;
    assign MEM_RDATA = MEM_ACK ? mem[idx] : churn;
    always @(posedge CLOCK) begin
        churn <= ~churn;
        if (!RST_N) begin
            wait_cnt <= 4'h0;
            n_acc <= 0;
        end else if (MEM_ACK) begin
            wait_cnt <= 4'h0;
            n_acc <= n_acc + 1;
            last_addr <= MEM_ADDR;
            last_size <= MEM_SIZE;
            last_user <= MEM_USER;
            if (MEM_WE && MEM_SIZE == 2'h0)
                mem[idx][lane+:8] <= MEM_WDATA[lane+:8];
            else if (MEM_WE && MEM_SIZE == 2'h1)
                mem[idx][{lane[4], 4'h0}+:16] <= MEM_WDATA[lane[4]*16+:16];
            else if (MEM_WE)
                mem[idx] <= MEM_WDATA;
        end else if (MEM_REQ) begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule : ldst_mem_model
`default_nettype wire

// file: test_ldst_unit.sv
// Self-checking bench for the load/store unit.
// Assumes ldst_pkg and ldst_mem_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_ldst_unit
    import ldst_pkg::*;
;
    logic        CLOCK, RST_N, INSTR_VALID, COND_PASS, CARRY_IN, INSTR_READY;
    logic        RD_WE, RN_WE, DONE, BAD_INSTR, MEM_REQ, MEM_WE, MEM_USER;
    logic        MEM_ACK, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
    logic [3:0]  RD_IDX, RN_IDX, WB_SEL_I, DELAY;
    logic [1:0]  MEM_SIZE;
    logic [7:0]  WB_ADR_I;
    logic [31:0] INSTR, RN_VALUE, RM_VALUE, RD_VALUE, MEM_RDATA, WB_DAT_I;
    logic [31:0] RD_DATA, RN_DATA, MEM_ADDR, MEM_WDATA, WB_DAT_O, r_rd, r_rn, q;
    logic        r_bad, r_rdwe, r_rnwe;
    int          n_mismatch, checks, cycles;
    ldst_unit ldst_unit_i (.CLOCK, .RST_N, .INSTR_VALID, .INSTR_READY, .INSTR,
        .COND_PASS, .CARRY_IN, .RN_VALUE, .RM_VALUE, .RD_VALUE, .RD_WE, .RD_IDX,
        .RD_DATA, .RN_WE, .RN_IDX, .RN_DATA, .DONE, .BAD_INSTR, .MEM_REQ,
        .MEM_WE, .MEM_SIZE, .MEM_USER, .MEM_ADDR, .MEM_WDATA, .MEM_RDATA,
        .MEM_ACK, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I,
        .WB_DAT_I, .WB_DAT_O, .WB_ACK_O);
    ldst_mem_model ldst_mem_model_i (.CLOCK, .RST_N, .DELAY, .MEM_REQ, .MEM_WE,
        .MEM_SIZE, .MEM_USER, .MEM_ADDR, .MEM_WDATA, .MEM_RDATA, .MEM_ACK);
    // ----------------------------------------------------------------
    // Encoders, comparison and bus tasks
    // ----------------------------------------------------------------
    // Word class: f holds I, P, U, B, W, L
    function automatic logic [31:0] enc_w(input logic [5:0] f,
        input logic [3:0] rn, input logic [11:0] off);
        return {4'he, 2'h1, f, rn, 4'h3, off};
    endfunction : enc_w
    // Halfword class: f holds P, U, I, W, L; sh holds S, H
    function automatic logic [31:0] enc_h(input logic [4:0] f,
        input logic [1:0] sh, input logic [7:0] off);
        return {4'he, 3'h0, f, 8'h23, off[7:4], 1'h1, sh, 1'h1, off[3:0]};
    endfunction : enc_h
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Holds the offer until taken, then waits for the finish pulse
    task automatic issue(input logic [31:0] ins, rn, rm, rd, input logic cp);
        INSTR_VALID <= 1'b1;
        INSTR <= ins;
        RN_VALUE <= rn;
        RM_VALUE <= rm;
        RD_VALUE <= rd;
        COND_PASS <= cp;
        do @(posedge CLOCK); while (INSTR_READY !== 1'b1);
        INSTR_VALID <= 1'b0;
        do @(posedge CLOCK); while (DONE !== 1'b1 && BAD_INSTR !== 1'b1);
        r_bad = BAD_INSTR;
        r_rdwe = RD_WE;
        r_rnwe = RN_WE;
        r_rd = RD_DATA;
        r_rn = RN_DATA;
    endtask : issue
    task automatic ld(input logic [31:0] ins, rn, rm, ea, ed);
        issue(ins, rn, rm, 32'h0, 1'b1);
        chk(ldst_mem_model_i.last_addr, ea);
        chk(r_rd, ed);
        chk({28'h0, RD_IDX}, 32'h3);
    endtask : ld
    // Classic single cycle, then one idle cycle
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= we;
        WB_ADR_I <= a;
        WB_DAT_I <= d;
        WB_SEL_I <= 4'hf;
        do @(posedge CLOCK); while (WB_ACK_O !== 1'b1);
        q = WB_DAT_O;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        @(posedge CLOCK);
    endtask : wb
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_word();
        ld(enc_w(6'h1b, 4'h2, 12'h004), 32'h40, 0, 32'h44, ldst_mem_model_i.mem[17]);
        chk(r_rn, 32'h44);
        chk({28'h0, RN_IDX}, 32'h2);
        chk({31'h0, ldst_mem_model_i.last_user}, 32'h0);
        issue(enc_w(6'h10, 4'h2, 12'h008), 32'h50, 0,
              32'hcafe_0123, 1'b1);
        chk(ldst_mem_model_i.mem[18], 32'hcafe_0123);
        chk({r_rnwe, r_rdwe}, 32'h0);
    endtask : t_word
    task automatic t_byte();
        logic [31:0] e;
        e = ldst_mem_model_i.mem[16];
        ld(enc_w(6'h1d, 4'h2, 12'h003), 32'h40, 0, 32'h43, {24'h0, e[31:24]});
        e = ldst_mem_model_i.mem[19];
        e[15:8] = 8'ha5;
        issue(enc_w(6'h1c, 4'h2, 12'h00d), 32'h40, 0,
              32'h1234_56a5, 1'b1);
        chk(ldst_mem_model_i.mem[19], e);
        chk({30'h0, ldst_mem_model_i.last_size}, {30'h0, SZ_BYTE});
    endtask : t_byte
    task automatic t_half();
        logic [31:0] e;
        DELAY <= 4'h5;
        e = ldst_mem_model_i.mem[16];
        ld(enc_h(5'h1d, 2'h1, 8'h82), 32'h40, 0, 32'hc2, {16'h0, ldst_mem_model_i.mem[48][31:16]});
        ld(enc_h(5'h1d, 2'h3, 8'h00), 32'h40, 0, 32'h40, {{16{e[15]}}, e[15:0]});
        ld(enc_h(5'h1d, 2'h2, 8'h01), 32'h40, 0, 32'h41, {{24{e[15]}}, e[15:8]});
        e = ldst_mem_model_i.mem[17];
        e[31:16] = 16'h5678;
        issue(enc_h(5'h1c, 2'h1, 8'h06), 32'h40, 0,
              32'h1234_5678, 1'b1);
        chk(ldst_mem_model_i.mem[17], e);
        DELAY <= 4'h0;
    endtask : t_half
    task automatic t_scaled();
        logic [31:0] offs [5];
        offs = '{32'h0000_0110, 32'h0800_0001, 32'hf800_0001, 32'h1800_0001,
                 32'hc000_0008};
        CARRY_IN <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            ld(enc_w(6'h29, 4'h2, {(k == 4) ? 5'h0 : 5'h4, (k == 4) ? 2'h3 : 2'(k), 5'h4}), 32'h40, 32'h8000_0011, 32'h40, ldst_mem_model_i.mem[16]);
            chk(r_rn, 32'h40 + offs[k]);
        end
        ld(enc_w(6'h33, 4'h2, 12'h004), 32'h40, 32'h8, 32'h38, ldst_mem_model_i.mem[14]);
        chk(r_rn, 32'h38);
        ld(enc_w(6'h19, 4'hf, 12'h040), 32'h108, 0, 32'h148, ldst_mem_model_i.mem[18]);
    endtask : t_scaled
    task automatic t_odd();
        int n;
        ld(enc_w(6'h0b, 4'h2, 12'h004), 32'h40, 0, 32'h40, ldst_mem_model_i.mem[16]);
        chk({31'h0, ldst_mem_model_i.last_user}, 32'h1);
        n = ldst_mem_model_i.n_acc;
        issue(enc_w(6'h1b, 4'h2, 12'h004), 32'h40, 0, 0, 1'b0);
        chk({r_bad, r_rnwe, r_rdwe}, 32'h0);
        issue(enc_w(6'h33, 4'h2, 12'h00f), 32'h40, 32'h8, 0, 1'b1);
        chk({31'h0, r_bad}, 32'h1);
        chk(ldst_mem_model_i.n_acc, n);
    endtask : t_odd
    task automatic t_regs();
        wb(1'b0, ADR_CTRL, 32'h0);
        chk(q, {31'h0, CTRL_RST});
        wb(1'b1, ADR_CTRL, 32'h0);
        chk({31'h0, INSTR_READY}, 32'h0);
        wb(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0);
        wb(1'b1, ADR_CTRL, 32'h1);
        wb(1'b0, ADR_STATUS, 32'h0);
        chk(q, 32'h0);
    endtask : t_regs
    task automatic summarize();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize
    // ----------------------------------------------------------------
    // Clock, hang guard and main sequence
    // ----------------------------------------------------------------
    initial begin
        CLOCK = 1'b0;
        forever #4 CLOCK = ~CLOCK;
    end
    // A stuck handshake would otherwise run forever
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            summarize();
        end
    end
    initial begin
        {RST_N, INSTR_VALID, COND_PASS, CARRY_IN, WB_CYC_I, WB_STB_I} = '0;
        {INSTR, RN_VALUE, RM_VALUE, RD_VALUE, WB_DAT_I} = '0;
        {WB_WE_I, WB_ADR_I, WB_SEL_I, DELAY} = '0;
        repeat (3) @(posedge CLOCK);
        RST_N <= 1'b1;
        @(posedge CLOCK);
        t_regs();
        t_word();
        t_byte();
        t_half();
        t_scaled();
        t_odd();
        summarize();
    end
endmodule : test_ldst_unit
`default_nettype wire
